// File: src/qvs_switch_on.sv
// valley switch-on control: soft start, up/down and valley counters
`timescale 1ns/1ps
`default_nettype none
module qvs_switch_on
    import qvs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
    parameter int unsigned SS_FORCE_CYCLES = SS_FORCE_CYC,
    parameter int unsigned LINE_BLANK_CYCLES = LINE_BLANK_CYC,
    parameter int unsigned OFF_MAX_CYCLES = OFF_MAX_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire qvs_cmp_t cmp_in,
    input wire logic gate_off,
    output logic gate_on_req,
    output logic [1:0] peak_limit_step,
    output logic soft_start_done,
    output logic [3:0] updown_value,
    output logic [3:0] valley_value
);
    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) $error("bad tick");
        // the force window is timed by the first step's count, so it must fit in it
        if (SS_STEP_CYCLES < 1 || SS_STEP_CYCLES > 16777215) $error("bad ss");
        if (SS_FORCE_CYCLES < 1 || SS_FORCE_CYCLES > SS_STEP_CYCLES) $error("bad ss force");
        if (OFF_MAX_CYCLES <= LONG_RS_CYC || OFF_MAX_CYCLES > 65535) $error("bad off max");
    end
    ////////////////////////////////////////////////////////////////////////////
    // minimum valley count follows the line class
    function automatic logic [3:0] line_min(input logic hi);
        return hi ? MIN_HIGH : MIN_LOW;
    endfunction
    function automatic logic [3:0] line_max(input logic hi);
        return hi ? MAX_HIGH : MAX_LOW;
    endfunction
    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_ON = 3'b010,
        ST_OFF = 3'b100
    } qvs_gate_st_t;
    typedef struct packed {
        qvs_gate_st_t gate;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic zcd_prev;
        logic [23:0] tick_cnt;
        logic seen_up;
        logic seen_down;
        logic seen_reset;
        logic [3:0] updown;
        logic [3:0] valley;
        logic [23:0] ss_cnt;
        logic [1:0] ss_step;
        logic ss_done;
        logic ss_force;
        logic [15:0] off_cnt;
        logic [15:0] rs_len;
        logic on_req;
        logic line_prev;
    } qvs_st_t;
    qvs_st_t st_q, st_d;
    qvs_cmp_t cs;
    logic line_high, line_valid, tick, crossing, rs_over;
    ////////////////////////////////////////////////////////////////////////////
    qvs_line_select #(.BLANK_CYC(LINE_BLANK_CYCLES)) u_line (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .above_high(cs.line_high),
        .below_low(cs.line_low),
        .line_high(line_high),
        .line_valid(line_valid)
    );
    // comparators are asynchronous to core_clk
    assign cs = qvs_cmp_t'(st_q.sync2);
    assign tick = st_q.tick_cnt == 24'(TICK_CYCLES - 1);
    assign crossing = st_q.zcd_prev && !cs.valley_crossing;
    assign rs_over = st_q.off_cnt >= st_q.rs_len;
    always_comb begin
        st_d = st_q;
        st_d.sync1 = 7'(cmp_in);
        st_d.sync2 = st_q.sync1;
        st_d.zcd_prev = cs.valley_crossing;
        st_d.on_req = 1'b0;
        st_d.line_prev = line_high;
        // soft start steps
        if (!st_q.ss_done && st_q.gate != ST_INIT) begin
            st_d.ss_cnt = st_q.ss_cnt + 24'h1;
            if (st_q.ss_cnt == 24'(SS_FORCE_CYCLES - 1)) begin
                st_d.ss_force = 1'b0;
            end
            if (st_q.ss_cnt == 24'(SS_STEP_CYCLES - 1)) begin
                st_d.ss_cnt = 24'h0;
                if (st_q.ss_step == SS_STEP_FULL) begin
                    st_d.ss_done = 1'b1;
                end else begin
                    st_d.ss_step = st_q.ss_step + 2'h1;
                end
            end
        end
        // up/down counter, stepped per tick; reset threshold and line change reload it at once
        st_d.tick_cnt = tick ? 24'h0 : st_q.tick_cnt + 24'h1;
        st_d.seen_up = st_q.seen_up | cs.fb_above_up;
        st_d.seen_down = st_q.seen_down | cs.fb_above_down;
        st_d.seen_reset = st_q.seen_reset | cs.fb_above_reset;
        if (cs.fb_above_reset || st_q.line_prev != line_high) begin
            st_d.updown = line_min(line_high);
        end else if (tick) begin
            if (st_q.seen_reset) begin
                st_d.updown = line_min(line_high);
            end else if (st_q.seen_down) begin
                if (st_q.updown > line_min(line_high)) begin
                    st_d.updown = st_q.updown - 4'h1;
                end
            end else if (!st_q.seen_up) begin
                if (st_q.updown < line_max(line_high)) begin
                    st_d.updown = st_q.updown + 4'h1;
                end
            end
            // otherwise hold
        end
        if (tick) begin
            st_d.seen_up = cs.fb_above_up;
            st_d.seen_down = cs.fb_above_down;
            st_d.seen_reset = cs.fb_above_reset;
        end
        unique case (st_q.gate)
            ST_INIT: begin
                if (line_valid) begin
                    st_d.updown = line_min(line_high);
                    st_d.on_req = 1'b1;
                    st_d.gate = ST_ON;
                    st_d.valley = 4'h0;
                end
            end
            ST_ON: begin
                if (gate_off) begin
                    st_d.gate = ST_OFF;
                    st_d.off_cnt = 16'h0;
                    st_d.valley = 4'h0;
                end
            end
            ST_OFF: begin
                if (st_q.off_cnt != 16'hffff) begin
                    st_d.off_cnt = st_q.off_cnt + 16'h1;
                end
                // synced level still shows the on-time drive until here
                if (st_q.off_cnt == 16'h3) begin
                    if (st_q.ss_force) begin
                        st_d.rs_len = 16'(FORCED_RS_CYC);
                    end else if (cs.zcd_above_rs) begin
                        st_d.rs_len = 16'(SHORT_RS_CYC);
                    end else begin
                        st_d.rs_len = 16'(LONG_RS_CYC);
                    end
                end
                // count valleys, clamp at line maximum
                if (crossing && st_q.valley < line_max(line_high)) begin
                    st_d.valley = st_q.valley + 4'h1;
                end
                if (st_q.off_cnt >= 16'(OFF_MAX_CYCLES - 1)) begin
                    st_d.on_req = 1'b1;
                end else if (rs_over && st_q.valley == st_q.updown) begin
                    st_d.on_req = 1'b1;
                end
                if (st_d.on_req) begin
                    st_d.gate = ST_ON;
                    st_d.valley = 4'h0;
                end
            end
            default: st_d.gate = ST_INIT;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.gate <= ST_INIT;
            st_q.ss_force <= 1'b1;
            st_q.updown <= MIN_LOW;
            st_q.rs_len <= 16'(LONG_RS_CYC);
        end else begin
            st_q <= st_d;
        end
    end
    assign gate_on_req = st_q.on_req;
    assign peak_limit_step = st_q.ss_step;
    assign soft_start_done = st_q.ss_done;
    assign updown_value = st_q.updown;
    assign valley_value = st_q.valley;
    ////////////////////////////////////////////////////////////////////////////
    property p_updown_range;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.gate != ST_INIT && $stable(line_high) |->
            updown_value >= line_min(line_high) && updown_value <= line_max(line_high);
    endproperty
    a_updown_range: assert property (p_updown_range) else $error("up/down out of range");
    property p_reset_min;
        @(posedge core_clk) disable iff (!rst_n)
        cs.fb_above_reset && st_q.gate != ST_INIT |=> updown_value == line_min($past(line_high));
    endproperty
    a_reset_min: assert property (p_reset_min) else $error("reset threshold ignored");
    property p_inc;
        @(posedge core_clk) disable iff (!rst_n)
        tick && !st_q.seen_up && !st_q.seen_down && !st_q.seen_reset
            && !cs.fb_above_reset && $stable(line_high)
            && st_q.gate != ST_INIT && updown_value < line_max(line_high)
            |=> updown_value == $past(updown_value) + 4'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("no increment");
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !tick && !cs.fb_above_reset && $stable(line_high) && st_q.gate != ST_INIT
            |=> $stable(updown_value);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved off tick");
    property p_rs_block;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.gate == ST_OFF && !rs_over |-> !st_d.on_req;
    endproperty
    a_rs_block: assert property (p_rs_block) else $error("turn-on in suppression");
    property p_match;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.gate == ST_OFF && rs_over && valley_value == updown_value |=> gate_on_req;
    endproperty
    a_match: assert property (p_match) else $error("valley match missed");
    property p_offmax;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.gate == ST_OFF && st_q.off_cnt == 16'(OFF_MAX_CYCLES - 1) |=> gate_on_req;
    endproperty
    a_offmax: assert property (p_offmax) else $error("off max missed");
    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        gate_on_req |-> valley_value == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("valley not cleared");
    property p_count;
        @(posedge core_clk) disable iff (!rst_n)
        st_q.gate == ST_OFF && crossing && !st_d.on_req && valley_value < line_max(line_high)
            |=> valley_value == $past(valley_value) + 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("crossing not counted");
    property p_ss_mono;
        @(posedge core_clk) disable iff (!rst_n)
        !soft_start_done |=> peak_limit_step >= $past(peak_limit_step);
    endproperty
    a_ss_mono: assert property (p_ss_mono) else $error("soft start stepped down");
    c_ss_done: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(soft_start_done));
    c_match: cover property (@(posedge core_clk) disable iff (!rst_n)
        gate_on_req && st_q.off_cnt < 16'(OFF_MAX_CYCLES - 1));
    c_offmax: cover property (@(posedge core_clk) disable iff (!rst_n)
        st_q.gate == ST_OFF && st_q.off_cnt == 16'(OFF_MAX_CYCLES - 1));
    c_high: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(line_high));
endmodule // qvs_switch_on
`default_nettype wire

// File: src/qvs_pkg.sv
// package: constants, types and timing for the valley switch-on control
package qvs_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SS_TIME_MS = 12;
    localparam int unsigned SS_STEPS = 4;
    localparam int unsigned SS_FORCE_MS = 3;
    localparam int unsigned TICK_MS = 48;
    localparam int unsigned FORCED_RS_US = 25;
    localparam int unsigned SHORT_RS_NS = 2500;
    localparam int unsigned LONG_RS_NS = 25000;
    localparam int unsigned LINE_BLANK_US = 500;
    localparam int unsigned OFF_MAX_US = 50;
    localparam int unsigned SS_STEP_CYC = CLK_HZ / 1000 * SS_TIME_MS / SS_STEPS;
    localparam int unsigned SS_FORCE_CYC = CLK_HZ / 1000 * SS_FORCE_MS;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned FORCED_RS_CYC = CLK_HZ / 1000000 * FORCED_RS_US;
    localparam int unsigned SHORT_RS_CYC = (CLK_HZ / 1000000 * SHORT_RS_NS + 999) / 1000;
    localparam int unsigned LONG_RS_CYC = (CLK_HZ / 1000000 * LONG_RS_NS + 999) / 1000;
    localparam int unsigned LINE_BLANK_CYC = CLK_HZ / 1000000 * LINE_BLANK_US;
    localparam int unsigned OFF_MAX_CYC = CLK_HZ / 1000000 * OFF_MAX_US;
    localparam logic [3:0] MIN_LOW = 4'h1;
    localparam logic [3:0] MIN_HIGH = 4'h3;
    localparam logic [3:0] MAX_LOW = 4'h8;
    localparam logic [3:0] MAX_HIGH = 4'ha;
    localparam logic [1:0] SS_STEP_FULL = 2'h3;
    typedef struct packed {
        logic fb_above_up;
        logic fb_above_down;
        logic fb_above_reset;
        logic line_high;
        logic line_low;
        logic valley_crossing;
        logic zcd_above_rs;
    } qvs_cmp_t;
endpackage

// File: src/qvs_line_select.sv
// line classification with hysteresis and blanking
`timescale 1ns/1ps
`default_nettype none
module qvs_line_select
    import qvs_pkg::*;
#(
    parameter int unsigned BLANK_CYC = LINE_BLANK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic above_high,
    input wire logic below_low,
    output logic line_high,
    output logic line_valid
);
    initial begin
        if (BLANK_CYC < 1 || BLANK_CYC > 1048575) $error("bad blanking");
    end
    typedef struct packed {
        logic [1:0] s_hi;
        logic [1:0] s_lo;
        logic [19:0] cnt;
        logic high;
        logic valid;
    } qvs_ls_st_t;
    qvs_ls_st_t st_q, st_d;
    logic want;
    always_comb begin
        st_d = st_q;
        st_d.s_hi = {st_q.s_hi[0], above_high};
        st_d.s_lo = {st_q.s_lo[0], below_low};
        // hysteresis band keeps the present class
        want = st_q.high ? !st_q.s_lo[1] : st_q.s_hi[1];
        if (want != st_q.high) begin
            // blanking: change only after a stable condition
            if (st_q.cnt >= 20'(BLANK_CYC - 1)) begin
                st_d.high = want;
                st_d.cnt = 20'h0;
            end else begin
                st_d.cnt = st_q.cnt + 20'h1;
            end
        end else begin
            st_d.cnt = 20'h0;
        end
        if (!st_q.valid && st_q.cnt == 20'h0 && st_q.s_hi == {2{st_q.s_hi[1]}}) begin
            st_d.valid = 1'b1;
            st_d.high = st_q.s_hi[1];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign line_high = st_q.high;
    assign line_valid = st_q.valid;
    property p_blank;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(line_high) && $past(line_valid) |-> $past(st_q.s_hi[1], 2);
    endproperty
    a_blank: assert property (p_blank) else $error("line went high without stable input");
endmodule // qvs_line_select
`default_nettype wire

// File: sim/qvs_drive_model.sv
// model of gate driver and auxiliary winding detector for the switch-on bench
`timescale 1ns/1ps
`default_nettype none
module qvs_drive_model
    import qvs_pkg::*;
#(
    parameter int unsigned ON_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic gate_on_req,
    input wire logic ring_en,
    input wire logic rs_level,
    input wire logic [15:0] ring_delay,
    output logic gate_off,
    output logic valley_crossing,
    output logic zcd_above_rs,
    output logic [15:0] off_len,
    output logic [7:0] cross_at_on
);
    logic on_q;
    logic [15:0] cnt_q;
    logic [7:0] cross_q;
    logic ringing;
    // ringing only while off and past the chosen delay; 20-cycle period
    assign ringing = !on_q && ring_en && (cnt_q >= ring_delay);
    // gate drive pulls the sense line high while on
    assign valley_crossing = !ringing || ((cnt_q - ring_delay) % 20 >= 10);
    assign zcd_above_rs = on_q || rs_level;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_q <= 1'b0;
            cnt_q <= 16'h0;
            cross_q <= 8'h0;
            gate_off <= 1'b0;
            off_len <= 16'h0;
            cross_at_on <= 8'h0;
        end else begin
            gate_off <= 1'b0;
            cnt_q <= cnt_q + 16'h1;
            if (gate_on_req && !on_q) begin
                on_q <= 1'b1;
                cnt_q <= 16'h0;
                off_len <= cnt_q;
                cross_at_on <= cross_q;
                cross_q <= 8'h0;
            end else if (on_q && cnt_q == 16'(ON_CYC)) begin
                gate_off <= 1'b1;
                on_q <= 1'b0;
                cnt_q <= 16'h0;
            end else if (ringing && (cnt_q - ring_delay) % 20 == 0) begin
                cross_q <= cross_q + 8'h1;
            end
        end
    end
endmodule // qvs_drive_model
`default_nettype wire

// File: sim/qr_valley_switch_on_control_tb.sv
// self-checking bench for the valley switch-on control
`timescale 1ns/1ps
`default_nettype none
module qr_valley_switch_on_control_tb;
    import qvs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fb_up = 1'b1, fb_dn = 1'b0, fb_rs = 1'b0, ln_hi = 1'b0, ln_lo = 1'b1;
    logic ring_en = 1'b1, rs_level = 1'b1;
    logic [15:0] ring_delay = 16'd600;
    logic gate_off, vc, zrs, gate_on_req, soft_start_done;
    logic [1:0] peak_limit_step;
    logic [3:0] updown_value, valley_value;
    logic [15:0] off_len;
    logic [7:0] cross_at_on;
    qvs_cmp_t cmp;
    int errors = 0, n_tests = 0, cyc = 0;
    assign cmp = {fb_up, fb_dn, fb_rs, ln_hi, ln_lo, vc, zrs};
    initial forever #25 core_clk = ~core_clk;
    qvs_switch_on #(.TICK_CYCLES(50), .SS_STEP_CYCLES(40), .SS_FORCE_CYCLES(30),
        .LINE_BLANK_CYCLES(4), .OFF_MAX_CYCLES(1000)) dut_u (.core_clk(core_clk),
        .rst_n(rst_n), .cmp_in(cmp), .gate_off(gate_off), .gate_on_req(gate_on_req),
        .peak_limit_step(peak_limit_step), .soft_start_done(soft_start_done),
        .updown_value(updown_value), .valley_value(valley_value));
    qvs_drive_model model_u (.core_clk(core_clk), .rst_n(rst_n), .gate_on_req(gate_on_req),
        .ring_en(ring_en), .rs_level(rs_level), .ring_delay(ring_delay),
        .gate_off(gate_off), .valley_crossing(vc), .zcd_above_rs(zrs), .off_len(off_len),
        .cross_at_on(cross_at_on));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic nw(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // bounded wait; sampling on the falling edge keeps clear of the launch edge
    task automatic wait_on();
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (gate_on_req !== 1'b1 && k < 1500);
        chk("turn-on seen", k < 1500, 1);
    endtask
    task automatic set_fb(input logic u, input logic d, input logic r);
        @(posedge core_clk);
        fb_up <= u;
        fb_dn <= d;
        fb_rs <= r;
    endtask
    task automatic set_line(input logic h, input logic l);
        @(posedge core_clk);
        ln_hi <= h;
        ln_lo <= l;
    endtask
    // off time and crossing count of the period that just ended
    task automatic off_check(input int lo, input int hi, input logic chk_cross);
        wait_on();
        wait_on();
        nw(1);
        chk("off time in range", off_len >= lo && off_len <= hi, 1);
        if (chk_cross)
            chk("crossings at turn-on", cross_at_on, 16'(updown_value));
        nw(2);
        chk("valley cleared", valley_value, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_start();
        nw(1);
        chk("updown at start", updown_value, 1);
        chk("step at start", peak_limit_step, 0);
        wait_on();
        chk("first step", peak_limit_step, 0);
        nw(20);
        chk("step 0", peak_limit_step, 0);
        nw(40);
        chk("step 1", peak_limit_step, 1);
        nw(40);
        chk("step 2", peak_limit_step, 2);
        nw(40);
        chk("step 3", peak_limit_step, 3);
        chk("ss running", soft_start_done, 0);
        nw(30);
        chk("ss done", soft_start_done, 1);
        wait_on();
        nw(1);
        chk("forced long off", off_len >= 500 && off_len <= 700, 1);
    endtask
    task automatic t_suppress();
        ring_delay <= 16'd60;
        off_check(50, 150, 1);
        rs_level <= 1'b0;
        off_check(500, 1010, 0);
        rs_level <= 1'b1;
    endtask
    task automatic t_updown();
        set_fb(0, 0, 0);
        nw(600);
        chk("updown low max", updown_value, 8);
        set_fb(1, 0, 0);
        nw(150);
        chk("updown hold", updown_value, 8);
        off_check(200, 400, 1);
        set_fb(1, 1, 0);
        nw(600);
        chk("updown low min", updown_value, 1);
        set_fb(0, 0, 0);
        nw(200);
        set_fb(1, 1, 1);
        set_fb(1, 0, 0);
        nw(10);
        chk("updown reset", updown_value, 1);
    endtask
    task automatic t_line();
        set_line(1, 0);
        nw(30);
        chk("high line min", updown_value, 3);
        set_line(0, 0);
        nw(50);
        chk("hysteresis band", updown_value, 3);
        set_fb(0, 0, 0);
        nw(600);
        chk("updown high max", updown_value, 10);
        set_fb(1, 0, 0);
        off_check(200, 400, 1);
        set_line(0, 1);
        set_line(0, 0);
        nw(30);
        chk("blanked glitch", updown_value, 10);
        set_line(0, 1);
        nw(30);
        chk("low line min", updown_value, 1);
    endtask
    task automatic longest_off_time();
        ring_en <= 1'b0;
        off_check(998, 1010, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // 20000 cycles leaves about two and a half times the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_start();
        t_suppress();
        t_updown();
        t_line();
        longest_off_time();
        finish_test();
    end
endmodule // qr_valley_switch_on_control_tb
`default_nettype wire
